// ===== core/vectored_interrupt_arbiter.sv
// interrupt acknowledge, enable/pending state and vector selection for the core
`timescale 1ns/1ps
// Summary of operation
// - every acknowledgement jumps to entry 00FF
// - trap ranks highest, default vector lowest
// - thirteen maskable sources with fixed rank, slot
// - per-source enable and pending, event sets pending
// - take maskable at boundary when fully qualified
// - highest-ranked qualified source wins, others wait
// - reset clears pending, enables and global enable
// - enabling an already pending source fires next boundary
// - maskable requests wait for next executed instruction start, traps are taken at once
// - ack clears global enable, pushes, loads entry
// - acknowledgement sequence lasts seven instruction cycles
// - status word write may re-enable for nesting
// - return sets global enable, retakes pending
// - boot ROM suppresses maskable interrupts (traps still taken), keeps global enable
// - vector select jumps through top qualified entry
// - table at top of block, last-address uses next
// - vector is 15 bits, high byte first
// - slots ascend with rank from E0 to FE
// - nothing qualified selects default slot E0
// - winner gives even low byte, high byte kept
// - trap pending set by trap, cleared by reset-opcode
module vectored_interrupt_arbiter #(
  parameter int N_SRC = irq_arb_pkg::NUM_SRC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tc_tick,
  input wire logic [12:0] src_event,
  input wire logic [12:0] pend_clr,
  input wire logic en_we,
  input wire logic [12:0] en_wdata,
  input wire irq_arb_pkg::psw_write_t psw_write,
  input wire logic boundary,
  input wire logic [14:0] ret_addr,
  input wire logic trap_event,
  input wire logic trap_pending_reset_opcode,
  input wire logic return_from_irq_opcode,
  input wire logic boot_rom_active,
  input wire logic vector_select_opcode,
  input wire logic [14:0] vis_pc,
  input wire logic vec_rd_valid,
  input wire logic [7:0] vec_rd_data,
  output logic vec_rd_req,
  output logic [14:0] vec_rd_addr,
  output irq_arb_pkg::pc_req_t push_req,
  output irq_arb_pkg::pc_req_t pc_load,
  output logic busy,
  output logic global_irq_enable,
  output logic trap_pending_flag,
  output logic [12:0] pending,
  output logic [12:0] enable
);
  import irq_arb_pkg::*;

  // source 0 ranks highest among maskables; slot 0 is the default entry
  function automatic logic [3:0] winner_slot(input logic [12:0] act, input logic trap);
    logic [3:0] s;
    s = DEFAULT_SLOT;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (act[i]) begin
        s = TOP_MASK_SLOT - 4'(i);
      end
    end
    if (trap) begin
      s = TRAP_SLOT;
    end
    return s;
  endfunction

  // a select opcode on a block's last byte reads the following block's table
  function automatic logic [14:0] vec_addr(input logic [14:0] pc, input logic [3:0] slot);
    logic [6:0] blk;
    blk = pc[14:8] + {6'h00, (pc[7:0] == BLOCK_LAST_LO)};
    return {blk, VEC_BASE_LO | {3'h0, slot, 1'b0}};
  endfunction

  arb_state_t state, next_state;
  logic [2:0] tc_cnt, next_tc_cnt;
  logic [12:0] next_pending, next_enable;
  logic next_gie, next_trap;
  logic [7:0] vec_hi, next_vec_hi;
  logic [14:0] next_vec_rd_addr;
  pc_req_t next_push, next_load;
  logic [12:0] active;
  logic mask_take, start;

  assign active = pending & enable;
  // qualification is sampled only on the boundary strobe, after any skip
  assign mask_take = boundary && (|active) && global_irq_enable && !trap_pending_flag
    && !boot_rom_active;
  assign start = (state == ST_IDLE) && (mask_take || trap_event);
  assign busy = (state != ST_IDLE);
  assign vec_rd_req = (state == ST_VEC_HI) || (state == ST_VEC_LO);

  always_comb begin
    next_pending = (pending & ~pend_clr) | src_event;
    next_enable = en_we ? en_wdata : enable;
    next_trap = trap_event ? 1'b1 :
      (trap_pending_reset_opcode ? 1'b0 : trap_pending_flag);
    next_gie = global_irq_enable;
    if (start) begin
      next_gie = 1'b0;
    end else if (return_from_irq_opcode || psw_write.set_one) begin
      next_gie = 1'b1;
    end else if (psw_write.clr_zero) begin
      next_gie = 1'b0;
    end
  end

  always_comb begin
    next_state = state;
    next_tc_cnt = tc_cnt;
    next_vec_hi = vec_hi;
    next_vec_rd_addr = vec_rd_addr;
    next_push = '0;
    next_load = '0;
    case (state)
      ST_IDLE: begin
        if (start) begin
          next_state = ST_ACK;
          next_tc_cnt = 3'h0;
          next_push.valid = 1'b1;
          next_push.addr = ret_addr;
        end else if (vector_select_opcode) begin
          next_state = ST_VEC_HI;
          next_vec_rd_addr = vec_addr(vis_pc, winner_slot(active, trap_pending_flag));
        end
      end
      ST_ACK: begin
        if (tc_tick) begin
          next_tc_cnt = tc_cnt + 3'h1;
          if (tc_cnt == ACK_TC - 3'h1) begin
            next_state = ST_IDLE;
            next_load.valid = 1'b1;
            next_load.addr = ENTRY_ADDR;
          end
        end
      end
      ST_VEC_HI: begin
        if (vec_rd_valid) begin
          next_vec_hi = vec_rd_data;
          next_vec_rd_addr = vec_rd_addr + 15'h0001;
          next_state = ST_VEC_LO;
        end
      end
      ST_VEC_LO: begin
        if (vec_rd_valid) begin
          next_load.valid = 1'b1;
          next_load.addr = {vec_hi[6:0], vec_rd_data};
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pending <= PEND_RST;
      enable <= EN_RST;
      global_irq_enable <= GIE_RST;
      trap_pending_flag <= 1'b0;
    end else begin
      pending <= next_pending;
      enable <= next_enable;
      global_irq_enable <= next_gie;
      trap_pending_flag <= next_trap;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      tc_cnt <= 3'h0;
      vec_hi <= 8'h00;
      vec_rd_addr <= 15'h0000;
      push_req <= '0;
      pc_load <= '0;
    end else begin
      state <= next_state;
      tc_cnt <= next_tc_cnt;
      vec_hi <= next_vec_hi;
      vec_rd_addr <= next_vec_rd_addr;
      push_req <= next_push;
      pc_load <= next_load;
    end
  end

  // checking helpers: independent tick count since the acknowledge began
  logic [3:0] hlp_ticks;
  logic hlp_in_ack;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hlp_ticks <= 4'h0;
      hlp_in_ack <= 1'b0;
    end else if (start) begin
      hlp_ticks <= 4'h0;
      hlp_in_ack <= 1'b1;
    end else begin
      if (tc_tick && hlp_in_ack) begin
        hlp_ticks <= hlp_ticks + 4'h1;
      end
      if (pc_load.valid) begin
        hlp_in_ack <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_ack_start;
    start && !trap_event;
  endsequence

  sequence seq_vec_pick;
    state == ST_IDLE && !start && vector_select_opcode;
  endsequence

  sequence seq_mask_ready;
    state == ST_IDLE && boundary && (|active) && global_irq_enable && !trap_pending_flag
    && !boot_rom_active;
  endsequence

  entry_load_a: assert property (
    pc_load.valid && hlp_in_ack |-> pc_load.addr == ENTRY_ADDR)
    else $error("acknowledge did not load the entry address");
  ack_len_a: assert property (
    pc_load.valid && hlp_in_ack |-> hlp_ticks == 4'h7)
    else $error("acknowledge length is not seven instruction cycles");
  ack_push_a: assert property (
    start |=> push_req.valid && push_req.addr == $past(ret_addr) && !global_irq_enable)
    else $error("acknowledge missed push or global enable clear");
  mask_qual_a: assert property (
    seq_ack_start |-> boundary && global_irq_enable && !trap_pending_flag && (|active))
    else $error("maskable taken without qualification");
  boot_block_a: assert property (
    boot_rom_active && !trap_event |-> !start)
    else $error("interrupt taken during boot ROM execution");
  pend_keep_a: assert property (
    seq_ack_start |=> (pending & $past(pending & ~pend_clr)) == $past(pending & ~pend_clr))
    else $error("acknowledge cleared a pending flag");
  pend_set_a: assert property (
    src_event != 13'h0000 |=> (pending & $past(src_event)) == $past(src_event))
    else $error("source event did not set pending");
  trap_hold_a: assert property (
    trap_pending_flag && !trap_pending_reset_opcode |=> trap_pending_flag [*2] or
    (trap_pending_flag ##1 !trap_pending_flag))
    else $error("trap pending dropped without reset opcode");
  return_from_irq_opcode_gie_a: assert property (
    return_from_irq_opcode && !start |=> global_irq_enable)
    else $error("return did not set global enable");
  vis_default_a: assert property (
    seq_vec_pick and (active == 13'h0000 && !trap_pending_flag) |=>
    vec_rd_addr[7:0] == VEC_BASE_LO)
    else $error("empty vector select did not use default slot");
  vis_trap_a: assert property (
    seq_vec_pick and trap_pending_flag |=> vec_rd_addr[7:0] == 8'hFE)
    else $error("trap did not win vector select");
  vis_top_a: assert property (
    seq_vec_pick and (active[0] && !trap_pending_flag) |=> vec_rd_addr[7:0] == 8'hFA)
    else $error("highest maskable source did not win");
  reset_clear_a: assert property (
    disable iff (1'b0) !rst_n |=> pending == 13'h0000 && enable == 13'h0000
    && !global_irq_enable && !trap_pending_flag)
    else $error("reset did not clear interrupt state");
  ack_busy_a: assert property (
    hlp_in_ack && !pc_load.valid |-> busy)
    else $error("core released before acknowledge finished");
  ack_done_a: assert property (
    hlp_in_ack && hlp_ticks == 4'h7 |-> pc_load.valid)
    else $error("entry load missing after seventh instruction cycle");
  push_pulse_a: assert property (
    push_req.valid |=> !push_req.valid)
    else $error("return address pushed twice");
  take_fire_a: assert property (
    seq_mask_ready |=> push_req.valid)
    else $error("qualified maskable request not taken at boundary");
  nest_gie_a: assert property (
    psw_write.set_one && !start |=> global_irq_enable)
    else $error("status word write did not set global enable");
  boot_gie_a: assert property (
    boot_rom_active && !start && !return_from_irq_opcode && psw_write == '0 |=>
    global_irq_enable == $past(global_irq_enable))
    else $error("global enable changed during boot ROM execution");
  trap_set_a: assert property (
    trap_event |=> trap_pending_flag)
    else $error("trap did not set its pending flag");
  trap_clr_a: assert property (
    trap_pending_reset_opcode && !trap_event |=> !trap_pending_flag)
    else $error("trap pending reset opcode did not clear the flag");
  pend_clr_a: assert property (
    (pend_clr & ~src_event) != 13'h0000 |=>
    (pending & $past(pend_clr & ~src_event)) == 13'h0000)
    else $error("software clear did not drop a pending flag");
  enable_wr_a: assert property (
    en_we |=> enable == $past(en_wdata))
    else $error("enable write not applied");
  vis_block_a: assert property (
    seq_vec_pick and (vis_pc[7:0] != BLOCK_LAST_LO) |=>
    vec_rd_addr[14:8] == $past(vis_pc[14:8]))
    else $error("vector table not in the select opcode block");
  vis_wrap_a: assert property (
    seq_vec_pick and (vis_pc[7:0] == BLOCK_LAST_LO) |=>
    vec_rd_addr[14:8] == $past(vis_pc[14:8]) + 7'h01)
    else $error("select on last byte did not use the next block");
  vis_even_a: assert property (
    seq_vec_pick |=> vec_rd_req && vec_rd_addr[7:5] == 3'h7 && !vec_rd_addr[0])
    else $error("vector slot address not even in the table range");
endmodule

// ===== core/irq_arb_pkg.sv
// constants and carrier types for the vectored interrupt arbiter
package irq_arb_pkg;
  localparam int NUM_SRC = 13;
  localparam int ADDR_W = 15;
  localparam logic [14:0] ENTRY_ADDR = 15'h00FF;
  localparam logic [2:0] ACK_TC = 3'h7;
  localparam logic [7:0] VEC_BASE_LO = 8'hE0;
  localparam logic [7:0] BLOCK_LAST_LO = 8'hFF;
  localparam logic [3:0] TRAP_SLOT = 4'hF;
  localparam logic [3:0] DEFAULT_SLOT = 4'h0;
  localparam logic [3:0] TOP_MASK_SLOT = 4'hD;
  localparam logic [12:0] PEND_RST = 13'h0000;
  localparam logic [12:0] EN_RST = 13'h0000;
  localparam logic GIE_RST = 1'b0;

  typedef struct packed {
    logic valid;
    logic [14:0] addr;
  } pc_req_t;

  typedef struct packed {
    logic set_one;
    logic clr_zero;
  } psw_write_t;

  typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_VEC_HI, ST_VEC_LO} arb_state_t;
endpackage

// ===== test/core_model.sv
// program memory side of the core: answers vector table byte fetches
`timescale 1ns/1ps
module core_model (
  input wire logic clk,
  input wire logic vec_rd_req,
  input wire logic [14:0] vec_rd_addr,
  input wire logic [1:0] lag,
  output logic vec_rd_valid,
  output logic [7:0] vec_rd_data
);
  logic [1:0] wait_cnt = 2'h0;
  // byte tied to its address so a wrong fetch shows up in the jump target
  always_comb begin
    vec_rd_valid = vec_rd_req && (wait_cnt == lag);
    vec_rd_data = vec_rd_addr[7:0] ^ 8'h5A;
    // no stale byte outside a valid beat, else a late sample could pass
    if (!vec_rd_valid) begin
      vec_rd_data = ~vec_rd_data;
    end
  end
  always_ff @(posedge clk) begin
    wait_cnt <= (vec_rd_valid || !vec_rd_req) ? 2'h0 : wait_cnt + 2'h1;
  end
endmodule

// ===== test/test_vectored_interrupt_arbiter.sv
// self-checking bench for the vectored interrupt arbiter
`timescale 1ns/1ps
module test_vectored_interrupt_arbiter;
  import irq_arb_pkg::*;
  logic clk = 0, rst_n = 0, tc_tick = 0, en_we = 0, boundary = 0, trap_event = 0;
  logic busy, vec_rd_req;
  logic trap_pending_reset_opcode = 0, return_from_irq_opcode = 0, vector_select_opcode = 0;
  logic boot_rom_active = 0, vec_rd_valid, global_irq_enable, trap_pending_flag;
  logic [12:0] src_event = 0, pend_clr = 0, en_wdata = 0, pending, enable;
  logic [14:0] ret_addr = 0, vis_pc = 0, vec_rd_addr;
  logic [7:0] vec_rd_data;
  logic [1:0] tdiv = 0, lag = 0;
  psw_write_t psw_write = '0;
  pc_req_t push_req, pc_load;
  int n_errors = 0, num_checks = 0, n_tick = 0, cycles = 0;

  vectored_interrupt_arbiter i_dut (.clk, .rst_n, .tc_tick, .src_event, .pend_clr, .en_we,
    .en_wdata, .psw_write, .boundary, .ret_addr, .trap_event, .trap_pending_reset_opcode,
    .return_from_irq_opcode, .boot_rom_active, .vector_select_opcode, .vis_pc,
    .vec_rd_valid, .vec_rd_data, .vec_rd_req, .vec_rd_addr, .push_req, .pc_load, .busy,
    .global_irq_enable, .trap_pending_flag, .pending, .enable);
  core_model i_core (.clk, .vec_rd_req, .vec_rd_addr, .lag, .vec_rd_valid, .vec_rd_data);

  initial begin
    forever #4 clk = ~clk;
  end
  // instruction cycle is four clocks, so the seven-cycle sequence is visible
  always @(posedge clk) begin
    if (tc_tick) n_tick++;
    cycles++;
    if (cycles > 5000) begin
      n_errors++;
      stop_test;
    end else begin
      #1;
      tdiv = tdiv + 2'h1;
      tc_tick = (tdiv == 2'h0);
    end
  end

  task stop_test;
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task cyc;
    @(posedge clk);
    #1;
    // strobes drop only if raised, so each gets one write per time step
    if (src_event !== 13'h0000) src_event = '0;
    if (pend_clr !== 13'h0000) pend_clr = '0;
    if (en_we !== 1'b0) en_we = 1'b0;
    if (psw_write !== 2'b00) psw_write = '0;
    if (boundary !== 1'b0) boundary = 1'b0;
    if (trap_event !== 1'b0) trap_event = 1'b0;
    if (trap_pending_reset_opcode !== 1'b0) trap_pending_reset_opcode = 1'b0;
    if (return_from_irq_opcode !== 1'b0) return_from_irq_opcode = 1'b0;
    if (vector_select_opcode !== 1'b0) vector_select_opcode = 1'b0;
  endtask
  task wait_load;
    int k;
    k = 0;
    while (pc_load.valid !== 1'b1 && k < 100) begin
      cyc;
      k++;
    end
  endtask
  task ack(input logic [14:0] ra, input logic take, input logic trap);
    ret_addr = ra;
    if (trap) trap_event = 1'b1;
    else boundary = 1'b1;
    cyc;
    chk(push_req.valid, take);
    if (take) begin
      chk(push_req.addr, ra);
      if (!trap) chk(global_irq_enable, 0);
      chk(busy, 1);
      n_tick = 0;
      wait_load;
      chk(n_tick, 7);
      chk(pc_load, {1'b1, ENTRY_ADDR});
      chk(busy, 0);
    end
  endtask
  task vsel(input logic [14:0] pc, input logic [7:0] lo);
    logic [14:0] a;
    a = {pc[14:8] + 7'(pc[7:0] == 8'hFF), lo};
    vis_pc = pc;
    vector_select_opcode = 1;
    cyc;
    chk(vec_rd_addr, a);
    chk(vec_rd_req, 1);
    wait_load;
    chk(pc_load, {1'b1, a[6:0] ^ 7'h5A, (a[7:0] + 8'h01) ^ 8'h5A});
    chk(vec_rd_req, 0);
  endtask

  initial begin
    repeat (3) cyc;
    rst_n = 1;
    chk({global_irq_enable, trap_pending_flag, pending, enable}, 0);
    src_event = 13'h0008;
    en_wdata = 13'h0008;
    cyc;
    chk(pending, 13'h0008);
    en_we = 1;
    cyc;
    ack(15'h1111, 0, 0);
    psw_write.set_one = 1;
    cyc;
    chk(global_irq_enable, 1);
    cyc;
    chk({busy, push_req.valid}, 0);
    ack(15'h1234, 1, 0);
    chk(pending, 13'h0008);
    return_from_irq_opcode = 1;
    cyc;
    chk(global_irq_enable, 1);
    ack(15'h2345, 1, 0);
    psw_write.set_one = 1;
    boot_rom_active = 1;
    cyc;
    ack(15'h3456, 0, 0);
    chk(global_irq_enable, 1);
    boot_rom_active = 0;
    ack(15'h0456, 1, 1);
    chk(trap_pending_flag, 1);
    psw_write.set_one = 1;
    cyc;
    ack(15'h0457, 0, 0);
    vsel(15'h0300, 8'hFE);
    trap_pending_reset_opcode = 1;
    cyc;
    chk(trap_pending_flag, 0);
    src_event = 13'h1FFF;
    cyc;
    // shrink the enabled set one rank at a time so each maskable slot wins once
    for (int i = 0; i < 13; i++) begin
      en_wdata = 13'h1FFF << i;
      en_we = 1;
      lag = 2'(i);
      cyc;
      vsel(15'h0123, 8'hE0 + 8'(2 * (13 - i)));
    end
    en_wdata = 0;
    en_we = 1;
    cyc;
    vsel(15'h01FF, 8'hE0);
    pend_clr = 13'h1FFF;
    cyc;
    chk(pending, 0);
    // load every flag, then reset in mid-acknowledge so the clear is not trivial
    src_event = 13'h1FFF;
    en_wdata = 13'h1FFF;
    en_we = 1;
    trap_event = 1;
    cyc;
    psw_write.set_one = 1;
    cyc;
    chk({busy, global_irq_enable, trap_pending_flag, pending & enable}, {3'h7, 13'h1FFF});
    rst_n = 0;
    cyc;
    rst_n = 1;
    chk({busy, global_irq_enable, trap_pending_flag, pending, enable}, 0);
    stop_test;
  end
endmodule
